// file: asr_pkg.sv
/*
 * constants for the async serial receive/transmit unit: register map,
 * control bit positions, status layout, oversampling figures.
 * assumes a 32-bit ahb-lite bus, one aligned word per register.
 */
package asr_pkg;
   // byte offsets of the registers
   localparam logic [7:0] ASR_OFS_CTRL1 = 8'h00;
   localparam logic [7:0] ASR_OFS_CTRL2 = 8'h04;
   localparam logic [7:0] ASR_OFS_DATA  = 8'h08;
   localparam logic [7:0] ASR_OFS_STAT  = 8'h0c;
   localparam logic [7:0] ASR_OFS_IEN   = 8'h10;
   localparam logic [7:0] ASR_OFS_ICLR  = 8'h14;
   localparam logic [7:0] ASR_OFS_BAUD  = 8'h18;

   // serial_control_one bit positions
   localparam int ASR_B_RX9  = 7;
   localparam int ASR_B_TX9  = 6;
   localparam int ASR_B_LPD  = 5;
   localparam int ASR_B_WLEN = 4;
   localparam int ASR_B_WAKE = 3;
   localparam int ASR_B_PCE  = 2;
   localparam int ASR_B_PODD = 1;
   localparam int ASR_B_PIE  = 0;
   localparam logic [7:0] ASR_CTRL1_RST = 8'h00;
   localparam logic [7:0] ASR_CTRL1_SWMASK = 8'h7f;

   // status / enable / clear layout; bits 0-4 sticky, bits 5 and 6 live busy
   localparam int ASR_S_RXDONE = 0;
   localparam int ASR_S_TXDONE = 1;
   localparam int ASR_S_NOISE  = 2;
   localparam int ASR_S_PAR    = 3;
   localparam int ASR_S_FRAME  = 4;
   localparam int ASR_S_RXBUSY = 5;
   localparam int ASR_S_TXBUSY = 6;
   localparam int ASR_NSTAT    = 5;

   // oversampling: sample numbers within one bit period
   localparam logic [4:0] ASR_SMP_LAST = 5'h10;
   localparam logic [4:0] ASR_SMP_V0   = 5'h08;
   localparam logic [4:0] ASR_SMP_V2   = 5'h0a;
   localparam logic [4:0] ASR_SMP_N0   = 5'h03;
   localparam logic [4:0] ASR_SMP_N1   = 5'h05;
   localparam logic [4:0] ASR_SMP_N2   = 5'h07;
   localparam logic [3:0] ASR_TX_LAST  = 4'hf;

   // frame lengths in bits, start and stop included
   localparam logic [3:0] ASR_FRM8 = 4'ha;
   localparam logic [3:0] ASR_FRM9 = 4'hb;
   // idle line for one whole frame, in samples
   localparam logic [7:0] ASR_IDLE8 = 8'ha0;
   localparam logic [7:0] ASR_IDLE9 = 8'hb0;

   localparam logic [15:0] ASR_BAUD_RST = 16'h000f;

   typedef enum logic [3:0] {
      ASR_RX_IDLE  = 4'b0001,
      ASR_RX_START = 4'b0010,
      ASR_RX_DATA  = 4'b0100,
      ASR_RX_STOP  = 4'b1000
   } asr_rx_e;

   typedef enum logic [1:0] {
      ASR_TX_IDLE  = 2'b01,
      ASR_TX_SHIFT = 2'b10
   } asr_tx_e;
endpackage

// file: asr_tx_if.sv
/*
 * interface between the register side and the transmit shifter.
 * assumes both ends run on hclk; tick is the 16x sampling enable.
 */
`timescale 1ns/1ns
interface asr_tx_if;
   logic        tick;
   logic        start;
   logic [10:0] frame;
   logic [3:0]  nbits;
   logic        busy;
   logic        done;
   logic        txd;
   modport ctrl (output tick, output start, output frame, output nbits,
                 input busy, input done, input txd);
   modport unit (input tick, input start, input frame, input nbits,
                 output busy, output done, output txd);
endinterface

// file: asr_tx.sv
/*
 * transmit shifter: sends a prepared frame lsb first, 16 ticks a bit.
 * assumes the frame already holds start, data, parity and stop bits.
 */
`timescale 1ns/1ns
module asr_tx
   import asr_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   asr_tx_if.unit    tx
);
   import asr_pkg::*;

   typedef struct packed {
      asr_tx_e     st;
      logic [10:0] sh;
      logic [3:0]  cnt;
      logic [3:0]  smp;
      logic        txd;
      logic        done;
   } asr_txst_s;

   asr_txst_s r;
   asr_txst_s next_r;

   // frame in progress keeps the settings it was built with
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      unique case (r.st)
         ASR_TX_IDLE: begin
            next_r.txd = 1'b1;
            if (tx.start) begin
               next_r.st  = ASR_TX_SHIFT;
               next_r.sh  = tx.frame;
               next_r.cnt = tx.nbits;
               next_r.smp = '0;
               next_r.txd = tx.frame[0];
            end
         end
         ASR_TX_SHIFT: begin
            if (tx.tick) begin
               next_r.smp = r.smp + 4'h1;
               if (r.smp == ASR_TX_LAST) begin
                  next_r.sh  = {1'b1, r.sh[10:1]};
                  next_r.txd = r.sh[1];
                  next_r.cnt = r.cnt - 4'h1;
                  if (r.cnt == 4'h1) begin
                     next_r.st   = ASR_TX_IDLE;
                     next_r.txd  = 1'b1;
                     next_r.done = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{st: ASR_TX_IDLE, sh: '1, cnt: '0, smp: '0, txd: 1'b1, done: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign tx.busy = (r.st == ASR_TX_SHIFT);
   assign tx.done = r.done;
   assign tx.txd  = r.txd;
endmodule

// file: asr_top.sv
/*
 * async serial unit: ahb-lite register slave, baud prescaler, 16x
 * oversampling receiver with noise checks, parity, wake-up and irq.
 * assumes rxd comes from a pin (synchronised here) and one clock hclk.
 */
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns

// Behaviour
// - total link deviation below 3.75 percent
// - start edge valid after three one samples (code starts after one one sample, sets noise if fewer than three)
// - start samples 3,5,7 one sets noise
// - start samples 8,9,10 one sets noise
// - data samples 8,9,10 unequal sets noise
// - data bit is majority of 8,9,10
// - nine-bit mode stores received ninth bit
// - nine-bit mode sends control bit six
// - low-power bit stops prescaler after byte
// - word length bit selects eight/nine bits
// - wake bit selects idle or address mark
// - parity inserted at msb and checked
// - parity enable change applies next byte
// - parity select even/odd, applies next byte
// - parity interrupt enable gates parity irq
module asr_top
   import asr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);
   import asr_pkg::*;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic        mute;
      logic [7:0]  ien;
      logic [ASR_NSTAT-1:0] stat;
      logic [15:0] baud;
      logic [15:0] pcnt;
      logic        tick;
      logic        rxd_s1;
      logic        rxd_s2;
      logic [2:0]  hist;
      asr_rx_e     rst;
      logic [4:0]  rsmp;
      logic [1:0]  vc;
      logic [3:0]  rbit;
      logic [8:0]  rsh;
      logic        rnoise;
      logic        rwide;
      logic        rpce;
      logic        rpodd;
      logic [7:0]  idle;
      logic [7:0]  rxdata;
      logic        dwr;
      logic [7:0]  daddr;
      logic [31:0] hrdata;
      logic        irq;
      logic        tx_start;
      logic [10:0] tx_frame;
      logic [3:0]  tx_nbits;
   } asr_st_s;

   asr_st_s r;
   asr_st_s next_r;
   asr_tx_if txi ();

   asr_tx u_tx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tx      (txi)
   );

   // straight register drives toward the shifter
   assign txi.tick  = r.tick;
   assign txi.start = r.tx_start;
   assign txi.frame = r.tx_frame;
   assign txi.nbits = r.tx_nbits;

   logic        s;
   logic [4:0]  n;
   logic [1:0]  vnew;
   logic        maj;
   logic        tx_busy;
   logic        rx_busy;
   logic [8:0]  w9;
   logic        msb;
   logic [8:0]  d9;
   logic [7:0]  d8;
   logic [ASR_NSTAT-1:0] sset;
   logic [ASR_NSTAT-1:0] sclr;
   logic [7:0]  ien_eff;
   logic        acc;
   logic [7:0]  wdat;

   always_comb begin
      next_r  = r;
      s       = r.rxd_s2;
      n       = r.rsmp + 5'h01;
      vnew    = r.vc;
      maj     = 1'b0;
      tx_busy = txi.busy | r.tx_start;
      rx_busy = (r.rst != ASR_RX_IDLE);
      w9      = r.rwide ? r.rsh : {1'b0, r.rsh[8:1]};
      msb     = r.rwide ? w9[8] : w9[7];
      d9      = '0;
      d8      = '0;
      sset    = '0;
      sclr    = '0;
      acc     = hsel & htrans[1] & hready;
      wdat    = hwdata[7:0];
      next_r.tick     = 1'b0;
      next_r.tx_start = 1'b0;

      // pin synchroniser; only the second stage is looked at
      next_r.rxd_s1 = rxd;
      next_r.rxd_s2 = r.rxd_s1;

      // prescaler runs unless low power is asked and no frame is live
      if (!r.ctrl[ASR_B_LPD] || tx_busy || rx_busy) begin
         // exact divide by baud+1: no quantisation drift within a frame
         if (r.pcnt >= r.baud) begin
            next_r.pcnt = '0;
            next_r.tick = 1'b1;
         end else begin
            next_r.pcnt = r.pcnt + 16'h0001;
         end
      end else begin
         next_r.pcnt = '0;
      end

      // receiver, advanced once per sample tick
      if (r.tick) begin
         next_r.hist = {r.hist[1:0], s};
         if (n >= ASR_SMP_V0 && n <= ASR_SMP_V2) begin
            vnew = r.vc + {1'b0, s};
         end
         maj = (vnew[1] == 1'b1);
         next_r.vc = vnew;
         next_r.rsmp = (n == ASR_SMP_LAST) ? 5'h00 : n;
         unique case (r.rst)
            ASR_RX_IDLE: begin
               next_r.rsmp = '0;
               next_r.vc   = '0;
               if (s && r.idle != '1) begin
                  next_r.idle = r.idle + 8'h01;
               end else if (!s) begin
                  next_r.idle = '0;
               end
               // idle-line wake after one whole frame of ones
               if (!r.ctrl[ASR_B_WAKE] && r.mute &&
                   r.idle >= (r.ctrl[ASR_B_WLEN] ? ASR_IDLE9 : ASR_IDLE8)) begin
                  next_r.mute = 1'b0;
               end
               if (r.hist[0] && !s && !r.ctrl[ASR_B_LPD]) begin
                  next_r.rst    = ASR_RX_START;
                  next_r.rsmp   = 5'h01;
                  next_r.rnoise = (r.hist != 3'b111);
                  // format and parity frozen for this frame
                  next_r.rwide  = r.ctrl[ASR_B_WLEN];
                  next_r.rpce   = r.ctrl[ASR_B_PCE];
                  next_r.rpodd  = r.ctrl[ASR_B_PODD];
                  next_r.rbit   = '0;
                  next_r.idle   = '0;
               end
            end
            ASR_RX_START: begin
               if (s && (n == ASR_SMP_N0 || n == ASR_SMP_N1 || n == ASR_SMP_N2)) begin
                  next_r.rnoise = 1'b1;
               end
               if (s && n >= ASR_SMP_V0 && n <= ASR_SMP_V2) begin
                  next_r.rnoise = 1'b1;
               end
               if (n == ASR_SMP_V2 && maj) begin
                  // mostly high in the middle: a glitch, not a start
                  next_r.rst = ASR_RX_IDLE;
                  sset[ASR_S_NOISE] = 1'b1;
               end else if (n == ASR_SMP_LAST) begin
                  next_r.rst = ASR_RX_DATA;
                  next_r.vc  = '0;
               end
            end
            ASR_RX_DATA: begin
               if (n == ASR_SMP_V2) begin
                  next_r.rsh = {maj, r.rsh[8:1]};
                  if (vnew != 2'b00 && vnew != 2'b11) begin
                     next_r.rnoise = 1'b1;
                  end
               end
               if (n == ASR_SMP_LAST) begin
                  next_r.vc   = '0;
                  next_r.rbit = r.rbit + 4'h1;
                  if (r.rbit == (r.rwide ? 4'h8 : 4'h7)) begin
                     next_r.rst = ASR_RX_STOP;
                  end
               end
            end
            ASR_RX_STOP: begin
               // finish mid stop bit so a following start is not missed
               if (n == ASR_SMP_V2) begin
                  next_r.rst = ASR_RX_IDLE;
                  if (r.mute && r.ctrl[ASR_B_WAKE] && msb) begin
                     next_r.mute = 1'b0;
                  end
                  if (!r.mute || (r.ctrl[ASR_B_WAKE] && msb)) begin
                     next_r.rxdata = w9[7:0];
                     if (r.rwide) begin
                        next_r.ctrl[ASR_B_RX9] = w9[8];
                     end
                     sset[ASR_S_RXDONE] = 1'b1;
                     sset[ASR_S_NOISE]  = r.rnoise | (vnew != 2'b00 && vnew != 2'b11);
                     sset[ASR_S_FRAME]  = ~maj;
                     sset[ASR_S_PAR]    = r.rpce & ((^w9) != r.rpodd);
                  end
               end
            end
            default: begin
               next_r.rst = ASR_RX_IDLE;
            end
         endcase
      end

      sset[ASR_S_TXDONE] = txi.done;

      // ahb-lite address phase: latch write target, prepare read data
      next_r.dwr = acc & hwrite;
      next_r.daddr = haddr[7:0];
      if (acc && !hwrite) begin
         unique case (haddr[7:0])
            ASR_OFS_CTRL1: next_r.hrdata = {24'h000000, r.ctrl};
            ASR_OFS_CTRL2: next_r.hrdata = {31'h00000000, r.mute};
            ASR_OFS_DATA:  next_r.hrdata = {24'h000000, r.rxdata};
            ASR_OFS_STAT:  next_r.hrdata = {25'h0000000, tx_busy, rx_busy, r.stat};
            ASR_OFS_IEN:   next_r.hrdata = {24'h000000, ien_eff};
            ASR_OFS_BAUD:  next_r.hrdata = {16'h0000, r.baud};
            default:       next_r.hrdata = '0;
         endcase
      end

      // ahb-lite data phase: apply the write
      if (r.dwr) begin
         unique case (r.daddr)
            ASR_OFS_CTRL1: begin
               next_r.ctrl = (next_r.ctrl & ~ASR_CTRL1_SWMASK) | (wdat & ASR_CTRL1_SWMASK);
            end
            ASR_OFS_CTRL2: next_r.mute = hwdata[0];
            ASR_OFS_IEN:   next_r.ien  = wdat;
            ASR_OFS_ICLR:  sclr = wdat[ASR_NSTAT-1:0];
            ASR_OFS_BAUD:  next_r.baud = hwdata[15:0];
            ASR_OFS_DATA: begin
               // ignored while a frame is queued, sending, or unit is off
               if (!tx_busy && !r.ctrl[ASR_B_LPD]) begin
                  d9 = {r.ctrl[ASR_B_TX9], wdat};
                  d8 = wdat;
                  if (r.ctrl[ASR_B_PCE]) begin
                     d9[8] = (^wdat) ^ r.ctrl[ASR_B_PODD];
                     d8[7] = (^wdat[6:0]) ^ r.ctrl[ASR_B_PODD];
                  end
                  next_r.tx_start = 1'b1;
                  if (r.ctrl[ASR_B_WLEN]) begin
                     next_r.tx_frame = {1'b1, d9, 1'b0};
                     next_r.tx_nbits = ASR_FRM9;
                  end else begin
                     next_r.tx_frame = {2'b11, d8, 1'b0};
                     next_r.tx_nbits = ASR_FRM8;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // sticky flags: a new event beats a clear in the same cycle
      next_r.stat = (r.stat & ~sclr) | sset;
      next_r.irq  = |(next_r.stat & ien_eff[ASR_NSTAT-1:0]);
   end

   // parity bit of the enable register mirrors the parity irq enable
   always_comb begin
      ien_eff = r.ien;
      ien_eff[ASR_S_PAR] = r.ctrl[ASR_B_PIE];
   end

   // all state but hreadyout and hresp in one register; ctrl bit 7 resets to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{ctrl: ASR_CTRL1_RST, mute: 1'b0, ien: '0, stat: '0,
                baud: ASR_BAUD_RST, pcnt: '0, tick: 1'b0, rxd_s1: 1'b1,
                rxd_s2: 1'b1, hist: 3'b111, rst: ASR_RX_IDLE, rsmp: '0,
                vc: '0, rbit: '0, rsh: '0, rnoise: 1'b0, rwide: 1'b0,
                rpce: 1'b0, rpodd: 1'b0, idle: '0, rxdata: '0, dwr: 1'b0,
                daddr: '0, hrdata: '0, irq: 1'b0, tx_start: 1'b0,
                tx_frame: '1, tx_nbits: '0};
      end else begin
         r <= next_r;
      end
   end

   // zero-wait slave, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata = r.hrdata;
   assign irq    = r.irq;
   assign txd    = txi.txd;  // flop inside the shifter
endmodule

// file: asr_sva.sv
/* checker for the async serial unit top: bus answer, txd bit timing.
   assumes one clock and that software writes baud 0 before timed sends. */
`timescale 1ns/1ns
module asr_sva
   import asr_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        irq
);
   localparam int QUIET = 180;
   localparam int MAXLOW = 160;
   logic        ap_v;
   logic        ap_w;
   logic [7:0]  ap_a;
   logic        lpd;
   logic [15:0] baud;
   logic [7:0]  quiet;
   logic [7:0]  low;
   logic        dtw;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // shadow of the writes that txd timing depends on, plus run lengths
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_v <= 1'h0;
         ap_w <= 1'h0;
         ap_a <= 8'h00;
         lpd <= 1'h0;
         baud <= ASR_BAUD_RST;
         quiet <= 8'h00;
         low <= 8'h00;
      end else begin
         ap_v <= hsel & htrans[1] & hready;
         ap_w <= hwrite;
         ap_a <= haddr[7:0];
         if (ap_v && ap_w && ap_a == ASR_OFS_CTRL1)
            lpd <= hwdata[ASR_B_LPD];
         if (ap_v && ap_w && ap_a == ASR_OFS_BAUD)
            baud <= hwdata[15:0];
         // saturating, so a long idle never wraps into a false start
         quiet <= !txd ? 8'h00 : (quiet == 8'hff ? quiet : quiet + 8'h01);
         low <= txd ? 8'h00 : (low == 8'hff ? low : low + 8'h01);
      end
   end
   assign dtw = ap_v && ap_w && ap_a == ASR_OFS_DATA;
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not okay");
   reset_idle_a: assert property ($rose(hresetn) |-> txd && !irq && hrdata == 32'h0)
      else $error("outputs not idle after reset");
   rdata_hold_a: assert property
      (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("hrdata moved without a read");
   tx_start_a: assert property (dtw && !lpd && quiet >= QUIET && baud == 16'h0
      |-> ##[1:4] !txd) else $error("send did not start");
   lp_hold_a: assert property (dtw && lpd && quiet >= QUIET |=> txd [*8])
      else $error("send not refused in low power");
   low_bit_a: assert property ($fell(txd) && baud == 16'h0
      |-> (!txd) [*8] ##1 (!txd) [*8]) else $error("low bit too short");
   high_bit_a: assert property ($rose(txd) && baud == 16'h0
      |-> txd [*8] ##1 txd [*8]) else $error("high bit too short");
   frame_len_a: assert property (baud == 16'h0 |-> low <= MAXLOW)
      else $error("txd low longer than a frame");
endmodule
bind asr_top asr_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
   .irq(irq));

// file: asr_remote.sv
/* remote serial station: sends frames on rxd, decodes frames on txd.
   assumes baud 0 in the unit, so one bit is 16 hclk cycles. */
`timescale 1ns/1ns
module asr_remote (
   input  wire logic hclk,
   input  wire logic txd,
   output logic      rxd
);
   localparam int BT = 16;
   logic [10:0] got;
   int          cnt = 0;
   initial rxd = 1'h1;
   // exact bit period: our share of the link deviation is zero
   task automatic send(input logic [10:0] f, input int n, input int g);
      for (int i = 0; i < n * BT; i++) begin
         @(posedge hclk);
         rxd <= f[i / BT] ^ (i == g); // one inverted sample at g
      end
   endtask
   // mid-bit samples; bit 10 of an 8-bit frame is idle high
   always begin
      @(negedge txd);
      repeat (BT / 2) @(posedge hclk);
      for (int i = 0; i < 11; i++) begin
         got[i] = txd;
         repeat (BT) @(posedge hclk);
      end
      cnt++;
   end
endmodule

// file: asr_tb.sv
/* bench for the async serial unit: ahb-lite tasks, remote station,
   one task per scenario. assumes the package map and baud 0. */
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   import asr_pkg::*;
   logic        hclk = 1'h0;
   logic        hresetn = 1'h0;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        rxd;
   logic        txd;
   logic        irq;
   logic [31:0] r;
   int          err_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [7:0]  mode [4] = '{8'h00, 8'h50, 8'h04, 8'h56};
   asr_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rxd(rxd), .txd(txd), .irq(irq));
   asr_remote u_rem (.hclk(hclk), .txd(txd), .rxd(rxd));
   always #2 hclk = ~hclk;
   // hang guard; the whole run needs about 3100 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   // one single transfer; read data lands in r
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      r = hrdata;
   endtask
   // expected line bits for a control value and a byte, lsb first
   function automatic logic [10:0] frame(input logic [7:0] c, input logic [7:0] d);
      logic [8:0] w;
      w = {c[ASR_B_TX9], d};
      if (c[ASR_B_PCE] && c[ASR_B_WLEN])
         w[8] = ^d ^ c[ASR_B_PODD];
      if (c[ASR_B_PCE] && !c[ASR_B_WLEN])
         w[7] = ^d[6:0] ^ c[ASR_B_PODD];
      return c[ASR_B_WLEN] ? {1'h1, w, 1'h0} : {2'h3, w[7:0], 1'h0};
   endfunction
   task automatic wait_rem(input int c0);
      for (int k = 0; k < 400 && u_rem.cnt == c0; k++) @(posedge hclk);
      `CHK(u_rem.cnt, c0 + 1)
   endtask
   // reset values, read-only ninth bit, unmapped offset
   task automatic t_regs();
      bus(1'h0, ASR_OFS_CTRL1, 32'h0);
      `CHK(r[7:0], ASR_CTRL1_RST)
      bus(1'h0, ASR_OFS_BAUD, 32'h0);
      `CHK(r[15:0], ASR_BAUD_RST)
      bus(1'h1, ASR_OFS_CTRL1, 32'hff);
      bus(1'h0, ASR_OFS_CTRL1, 32'h0);
      `CHK(r[7:0], ASR_CTRL1_SWMASK)
      bus(1'h0, 8'h1c, 32'h0);
      `CHK(r, 32'h0)
      bus(1'h1, ASR_OFS_CTRL1, 32'h0);
      bus(1'h1, ASR_OFS_BAUD, 32'h0);
   endtask
   // every mode out on txd; parity bits flipped while the frame runs
   task automatic t_tx();
      int c0;
      for (int i = 0; i < 4; i++) begin
         c0 = u_rem.cnt;
         bus(1'h1, ASR_OFS_CTRL1, {24'h0, mode[i]});
         bus(1'h1, ASR_OFS_DATA, 32'hcb);
         bus(1'h1, ASR_OFS_CTRL1, {24'h0, mode[i] ^ 8'h06});
         wait_rem(c0);
         `CHK(u_rem.got, frame(mode[i], 8'hcb))
         bus(1'h0, ASR_OFS_STAT, 32'h0);
         `CHK(r[6:0], 7'h02)
         bus(1'h1, ASR_OFS_ICLR, 32'h1f);
      end
   endtask
   // every mode in on rxd; byte, ninth bit, clean status
   task automatic t_rx();
      logic [10:0] f;
      for (int i = 0; i < 4; i++) begin
         f = frame(mode[i], 8'hcb);
         bus(1'h1, ASR_OFS_CTRL1, {24'h0, mode[i]});
         u_rem.send(f, mode[i][ASR_B_WLEN] ? 11 : 10, -1);
         repeat (4) @(posedge hclk);
         bus(1'h0, ASR_OFS_DATA, 32'h0);
         `CHK(r[7:0], f[8:1])
         bus(1'h0, ASR_OFS_CTRL1, 32'h0);
         if (mode[i][ASR_B_WLEN])
            `CHK(r[ASR_B_RX9], f[9])
         bus(1'h0, ASR_OFS_STAT, 32'h0);
         `CHK(r[6:0], 7'h01)
         bus(1'h1, ASR_OFS_ICLR, 32'h1f);
      end
   endtask
   // one bad sample in start bit (5, 9) and in data bit 2 (9)
   task automatic t_noise();
      int         g [3] = '{4, 8, 56};
      logic [7:0] d;
      bus(1'h1, ASR_OFS_CTRL1, 32'h0);
      for (int i = 0; i < 3; i++) begin
         d = {5'h0b, i[2:0]};
         u_rem.send(frame(8'h00, d), 10, g[i]);
         repeat (4) @(posedge hclk);
         bus(1'h0, ASR_OFS_DATA, 32'h0);
         `CHK(r[7:0], d)
         bus(1'h0, ASR_OFS_STAT, 32'h0);
         `CHK(r[ASR_S_NOISE], 1'h1)
         bus(1'h1, ASR_OFS_ICLR, 32'h1f);
      end
   endtask
   // wrong parity with the irq enable set, then clear
   task automatic t_par();
      logic [10:0] f;
      for (int i = 0; i < 2; i++) begin
         f = frame(8'h16, 8'hcb);
         f[9] = ~f[9];
         bus(1'h1, ASR_OFS_CTRL1, {24'h0, 7'h0b, i == 0});
         u_rem.send(f, 11, -1);
         repeat (4) @(posedge hclk);
         bus(1'h0, ASR_OFS_STAT, 32'h0);
         `CHK(r[ASR_S_PAR], 1'h1)
         `CHK(irq, i == 0)
         bus(1'h1, ASR_OFS_ICLR, 32'h1f);
         bus(1'h0, ASR_OFS_IEN, 32'h0);
         `CHK(r[ASR_S_PAR], i == 0)
         `CHK(irq, 1'h0)
      end
   endtask
   // muted receiver ignores a plain byte, wakes on an address mark
   task automatic t_wake();
      bus(1'h1, ASR_OFS_CTRL1, 32'h08);
      bus(1'h1, ASR_OFS_CTRL2, 32'h01);
      u_rem.send(frame(8'h00, 8'h12), 10, -1);
      repeat (4) @(posedge hclk);
      bus(1'h0, ASR_OFS_STAT, 32'h0);
      `CHK(r[ASR_S_RXDONE], 1'h0)
      u_rem.send(frame(8'h00, 8'h92), 10, -1);
      repeat (4) @(posedge hclk);
      bus(1'h0, ASR_OFS_DATA, 32'h0);
      `CHK(r[7:0], 8'h92)
      bus(1'h0, ASR_OFS_CTRL2, 32'h0);
      `CHK(r[0], 1'h0)
   endtask
   // low-power bit refuses an all-zero byte, txd stays idle
   task automatic t_lp();
      int c0;
      c0 = u_rem.cnt;
      bus(1'h1, ASR_OFS_CTRL1, 32'h20);
      bus(1'h1, ASR_OFS_DATA, 32'h00);
      repeat (40) @(posedge hclk);
      `CHK(txd, 1'h1)
      bus(1'h0, ASR_OFS_STAT, 32'h0);
      `CHK(r[ASR_S_TXBUSY], 1'h0)
      repeat (200) @(posedge hclk);
      `CHK(u_rem.cnt, c0)
      bus(1'h1, ASR_OFS_CTRL1, 32'h0);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs();
      t_tx();
      t_rx();
      t_noise();
      t_par();
      t_wake();
      t_lp();
      summarize();
   end
endmodule
